/* pscfg_top.sv */
// Purpose: Write protection for system registers plus transfer, debug, oscillator and watchdog control.
// Assumes: CPU requests come from logic on clk_i; the debug reset pin is asynchronous.
// Notes:   rst_n_i is the external reset pin; int_rst_i is an internal reset source.
// Contract
// - Seven system registers accept writes only right after a protect command write.
// - A guarded store without the preceding command sets the illegal-store status flag.
// - Each channel control holds enable at bit 0; 1 enables, 0 disables.
// - All channel control registers reset to zero, channels disabled.
// - Debug mode register writes take effect only while debug reset pin is low.
// - External reset pin sets the debug mode register to one.
// - Watchdog, clock monitor or low-voltage resets keep debug mode contents.
// - Debug bit 0 gives normal mode, port use, pull-down disconnected.
// - Debug bit 1 gives debug pin function only while debug reset pin is high.
// - Oscillator mode stop bit runs oscillator at 0, stops at 1; resets zero.
// - After reset the watchdog runs in reset mode with its reset value.
// - Watchdog mode 00 stops, 01 interrupts, upper bit set resets on overflow.
// - Watchdog mode register sets overflow interval and counting clock.
`timescale 1ns/1ps
module pscfg_top #(
	parameter int unsigned NCHAN   = 4,
	parameter int unsigned OSC_DIV = pscfg_pkg::OSC_DIV,
	parameter int unsigned WD_CNT_W = 24
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  int_rst_i,
	input  wire logic                  debug_reset_pin_i,
	input  wire logic [NCHAN-1:0]      terminal_count_flag_i,
	input  wire pscfg_pkg::pscfg_req_t req_i,
	output logic [7:0]                 rdata_o,
	output logic                       rvalid_o,
	output logic [NCHAN-1:0]           chan_en_o,
	output logic [NCHAN-1:0]           chan_init_o,
	output logic [NCHAN-1:0]           soft_trig_o,
	output pscfg_pkg::pscfg_gwr_t      gwr_o,
	output logic                       illegal_store_o,
	output logic                       debug_func_o,
	output logic                       dbg_pulldown_o,
	output logic                       osc_stop_o,
	output logic                       wd_nmi_request_o,
	output logic                       wd_reset_request_o
);

	localparam int unsigned OSC_CNT_W = $clog2(OSC_DIV + 1);

	logic [7:0]           dbg_mode_r;
	logic [7:0]           osc_mode_r;
	logic [7:0]           wd_mode_r;
	logic [7:0]           sys_r;
	logic [7:0]           status_nv;
	logic                 unlock_r;
	logic                 dbg_pin_s1_r;
	logic                 dbg_pin_r;
	logic [NCHAN-1:0]     chan_en_r;
	logic [OSC_CNT_W-1:0] osc_cnt_r;
	logic              osc_tick_r;
	logic              wr;
	logic              is_cmd;
	logic              guard_hit;
	logic [2:0]        guard_sel;
	logic              guard_ok;
	logic              guard_bad;
	logic              wd_tick;
	logic              wd_nmi;
	logic              wd_res;
	logic [NCHAN-1:0]  chan_hit;

	localparam logic [NCHAN*32-1:0] CHAN_ADDRS = {pscfg_pkg::ADDR_XFER_CHAN3, pscfg_pkg::ADDR_XFER_CHAN2,
		pscfg_pkg::ADDR_XFER_CHAN1, pscfg_pkg::ADDR_XFER_CHAN0};

	// Debug reset pin comes straight from a pad.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dbg_pin_s1_r <= 1'b0;
			dbg_pin_r    <= 1'b0;
		end else begin
			dbg_pin_s1_r <= debug_reset_pin_i;
			dbg_pin_r    <= dbg_pin_s1_r;
		end
	end

	always_comb begin
		wr        = req_i.wr;
		is_cmd    = req_i.addr == pscfg_pkg::ADDR_PROTECT_CMD;
		guard_hit = 1'b0;
		guard_sel = 3'h0;
		for (int i = 0; i < pscfg_pkg::NGUARD; i++) begin
			if (req_i.addr == pscfg_pkg::GUARD_ADDRS[i*32 +: 32]) begin
				guard_hit = 1'b1;
				guard_sel = 3'(i);
			end
		end
		guard_ok  = wr && guard_hit && unlock_r;
		guard_bad = wr && guard_hit && !unlock_r;
		status_nv = pscfg_pkg::pscfg_apply(sys_r, req_i);
		for (int c = 0; c < NCHAN; c++) begin
			chan_hit[c] = wr && (req_i.addr == CHAN_ADDRS[c*32 +: 32]);
		end
	end

	// The unlock lives for exactly one store; a runaway loop that writes anything else loses it.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unlock_r <= 1'b0;
		end else if (int_rst_i) begin
			unlock_r <= 1'b0;
		end else if (wr) begin
			unlock_r <= is_cmd;
		end
	end

	// Illegal-store flag: hardware set wins over a software clear in the same cycle.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_r <= pscfg_pkg::SYS_RST;
		end else if (int_rst_i) begin
			sys_r <= pscfg_pkg::SYS_RST;
		end else if (guard_bad) begin
			sys_r[pscfg_pkg::SYS_ILLEGAL_BIT] <= 1'b1;
		end else if (wr && req_i.addr == pscfg_pkg::ADDR_SYS_STATUS) begin
			sys_r[pscfg_pkg::SYS_ILLEGAL_BIT] <= status_nv[pscfg_pkg::SYS_ILLEGAL_BIT];
		end
	end

	// Guarded registers other than debug mode live elsewhere; they receive the accepted store here.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gwr_o <= '0;
		end else begin
			gwr_o.valid <= guard_ok && guard_sel != pscfg_pkg::GSEL_DEBUG_MODE;
			gwr_o.sel   <= guard_sel;
			gwr_o.op    <= req_i.op;
			gwr_o.bitn  <= req_i.bitn;
			gwr_o.data  <= req_i.wdata;
		end
	end

	// Only the external reset pin reaches this register, so internal resets leave it alone.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dbg_mode_r <= pscfg_pkg::DEBUG_MODE_RST;
		end else if (guard_ok && guard_sel == pscfg_pkg::GSEL_DEBUG_MODE && !dbg_pin_r && !int_rst_i) begin
			dbg_mode_r <= pscfg_pkg::pscfg_apply(dbg_mode_r, req_i) & 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			debug_func_o   <= 1'b0;
			dbg_pulldown_o <= 1'b1;
		end else begin
			debug_func_o   <= dbg_mode_r[pscfg_pkg::DEBUG_MODE_BIT] && dbg_pin_r;
			dbg_pulldown_o <= dbg_mode_r[pscfg_pkg::DEBUG_MODE_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_mode_r <= pscfg_pkg::OSC_MODE_RST;
		end else if (int_rst_i) begin
			osc_mode_r <= pscfg_pkg::OSC_MODE_RST;
		end else if (wr && req_i.addr == pscfg_pkg::ADDR_OSC_MODE) begin
			osc_mode_r <= pscfg_pkg::pscfg_apply(osc_mode_r, req_i) & 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_stop_o <= 1'b0;
		end else begin
			osc_stop_o <= osc_mode_r[pscfg_pkg::OSC_STOP_BIT];
		end
	end

	// Internal oscillator stand-in; a stopped oscillator also starves a watchdog counting it.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_cnt_r  <= '0;
			osc_tick_r <= 1'b0;
		end else if (osc_mode_r[pscfg_pkg::OSC_STOP_BIT]) begin
			osc_cnt_r  <= '0;
			osc_tick_r <= 1'b0;
		end else if (osc_cnt_r == OSC_CNT_W'(OSC_DIV - 1)) begin
			osc_cnt_r  <= '0;
			osc_tick_r <= 1'b1;
		end else begin
			osc_cnt_r  <= osc_cnt_r + 1'b1;
			osc_tick_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wd_mode_r <= pscfg_pkg::WD_MODE_RST;
		end else if (int_rst_i) begin
			wd_mode_r <= pscfg_pkg::WD_MODE_RST;
		end else if (wr && req_i.addr == pscfg_pkg::ADDR_WD_MODE) begin
			wd_mode_r <= pscfg_pkg::pscfg_apply(wd_mode_r, req_i);
		end
	end

	assign wd_tick = wd_mode_r[pscfg_pkg::WD_CLKSEL_BIT] ? 1'b1 : osc_tick_r;

	pscfg_wdog #(
		.CNT_W    (WD_CNT_W),
		.BASE_LOG (pscfg_pkg::WD_BASE_LOG)
	) pscfg_wdog_i (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.srst_i    (int_rst_i),
		.tick_i    (wd_tick),
		.mode_i    ({wd_mode_r[pscfg_pkg::WD_MODE_HI_BIT], wd_mode_r[pscfg_pkg::WD_MODE_LO_BIT]}),
		.intv_i    (wd_mode_r[pscfg_pkg::WD_INTV_LSB +: pscfg_pkg::WD_INTV_W]),
		.restart_i (wr && (req_i.addr == pscfg_pkg::ADDR_WD_RESTART || req_i.addr == pscfg_pkg::ADDR_WD_MODE)),
		.nmi_o     (wd_nmi),
		.res_o     (wd_res)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wd_nmi_request_o   <= 1'b0;
			wd_reset_request_o <= 1'b0;
		end else begin
			wd_nmi_request_o   <= wd_nmi;
			wd_reset_request_o <= wd_res;
		end
	end

	// Trigger and init bits are write-only strobes; they read back as zero.
	for (genvar c = 0; c < NCHAN; c++) begin : g_chan
		logic [7:0] chan_nv;
		assign chan_nv = pscfg_pkg::pscfg_apply({7'h00, chan_en_r[c]}, req_i);
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				chan_en_r[c]   <= pscfg_pkg::XFER_CHAN_RST[pscfg_pkg::CHAN_EN_BIT];
				chan_init_o[c] <= 1'b0;
				soft_trig_o[c] <= 1'b0;
			end else if (int_rst_i) begin
				chan_en_r[c]   <= pscfg_pkg::XFER_CHAN_RST[pscfg_pkg::CHAN_EN_BIT];
				chan_init_o[c] <= 1'b0;
				soft_trig_o[c] <= 1'b0;
			end else begin
				if (chan_hit[c]) begin
					chan_en_r[c] <= chan_nv[pscfg_pkg::CHAN_EN_BIT];
				end
				chan_init_o[c] <= chan_hit[c] && chan_nv[pscfg_pkg::CHAN_INIT_BIT];
				soft_trig_o[c] <= chan_hit[c] && chan_nv[pscfg_pkg::CHAN_TRIG_BIT];
			end
		end
	end

	assign chan_en_o       = chan_en_r;
	assign illegal_store_o = sys_r[pscfg_pkg::SYS_ILLEGAL_BIT];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= req_i.rd;
			rdata_o  <= 8'h00;
			if (req_i.rd) begin
				if (req_i.addr == pscfg_pkg::GUARD_ADDRS[pscfg_pkg::GSEL_DEBUG_MODE*32 +: 32]) begin
					rdata_o <= dbg_mode_r;
				end else if (req_i.addr == pscfg_pkg::ADDR_OSC_MODE) begin
					rdata_o <= osc_mode_r;
				end else if (req_i.addr == pscfg_pkg::ADDR_WD_MODE) begin
					rdata_o <= wd_mode_r;
				end else if (req_i.addr == pscfg_pkg::ADDR_SYS_STATUS) begin
					rdata_o <= sys_r;
				end else begin
					for (int c = 0; c < NCHAN; c++) begin
						if (req_i.addr == CHAN_ADDRS[c*32 +: 32]) begin
							rdata_o <= {terminal_count_flag_i[c], 6'h00, chan_en_r[c]};
						end
					end
				end
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_cmd;
		wr && is_cmd && !int_rst_i;
	endsequence

	// The store sequences below are spaced by one idle cycle, the pattern a CPU store loop produces.
	sequence s_gap;
		!wr;
	endsequence

	sequence s_guarded_store;
		wr && guard_hit && guard_sel != pscfg_pkg::GSEL_DEBUG_MODE && !int_rst_i;
	endsequence

	sequence s_other_store;
		wr && !is_cmd && !guard_hit && !int_rst_i;
	endsequence

	a_protect_seq: assert property (s_cmd ##1 s_gap ##1 s_guarded_store |=> gwr_o.valid)
		else $error("protected store after command was not passed on");

	a_unguarded_block: assert property (wr && guard_hit && !unlock_r && !int_rst_i
		|=> !gwr_o.valid && illegal_store_o)
		else $error("unprotected store was accepted or not flagged");

	a_unlock_cancel: assert property (s_cmd ##1 s_gap ##1 s_other_store ##1 s_gap ##1 s_guarded_store
		|=> !gwr_o.valid)
		else $error("unlock survived an intervening write");

	a_gwr_single: assert property (gwr_o.valid |=> !gwr_o.valid)
		else $error("guarded store passed on twice from one unlock");

	a_flag_set_wins: assert property (guard_bad && !int_rst_i |=> sys_r[pscfg_pkg::SYS_ILLEGAL_BIT])
		else $error("illegal store flag lost");

	a_debug_pin_gate: assert property (wr && guard_hit && guard_sel == pscfg_pkg::GSEL_DEBUG_MODE && dbg_pin_r
		|=> $stable(dbg_mode_r))
		else $error("debug mode written while debug reset pin high");

	a_debug_keep: assert property (int_rst_i |=> $stable(dbg_mode_r))
		else $error("internal reset changed debug mode");

	a_debug_normal: assert property (!dbg_mode_r[0] ##1 !dbg_mode_r[0] |=> !debug_func_o && !dbg_pulldown_o)
		else $error("debug pins active with debug bit clear");

	a_debug_func: assert property (dbg_mode_r[0] && dbg_pin_r ##1 dbg_mode_r[0] && dbg_pin_r |=> debug_func_o)
		else $error("debug function not given with bit set and pin high");

	a_chan_reset: assert property (int_rst_i |=> chan_en_o == '0 && chan_init_o == '0)
		else $error("channel enables not cleared by reset");

	a_chan_enable: assert property (chan_hit[0] && !int_rst_i
		&& ((req_i.op == pscfg_pkg::PSCFG_OP_SET && req_i.bitn == 3'h0)
		|| (req_i.op == pscfg_pkg::PSCFG_OP_STORE && req_i.wdata[0])) |=> chan_en_o[0])
		else $error("channel 0 enable did not set");

	a_osc_stop: assert property (osc_mode_r[0] |=> osc_stop_o ##1 !osc_tick_r)
		else $error("oscillator stop not applied");

	a_wd_reset_val: assert property (int_rst_i |=> wd_mode_r == pscfg_pkg::WD_MODE_RST)
		else $error("watchdog mode not restored by reset");

endmodule

/* pscfg_pkg.sv */
// Purpose: Shared constants and carrier types for the protected system configuration block.
// Assumes: One 25 MHz system clock; CPU stores arrive as one-cycle requests.
// Notes:   Addresses are byte addresses of 8-bit registers.
package pscfg_pkg;

	localparam int unsigned CLK_HZ = 25_000_000;

	typedef enum logic [1:0] {
		PSCFG_OP_STORE,
		PSCFG_OP_SET,
		PSCFG_OP_CLR,
		PSCFG_OP_NOT
	} pscfg_op_t;

	typedef struct packed {
		logic            wr;
		logic            rd;
		logic [31:0]     addr;
		pscfg_op_t       op;
		logic [2:0]      bitn;
		logic [7:0]      wdata;
	} pscfg_req_t;

	typedef struct packed {
		logic            valid;
		logic [2:0]      sel;
		pscfg_op_t       op;
		logic [2:0]      bitn;
		logic [7:0]      data;
	} pscfg_gwr_t;

	localparam logic [31:0] ADDR_PROTECT_CMD   = 32'hffff_f1fc;
	localparam logic [31:0] ADDR_SYS_STATUS    = 32'hffff_f802;
	localparam logic [31:0] ADDR_XFER_CHAN0    = 32'hffff_f0e0;
	localparam logic [31:0] ADDR_XFER_CHAN1    = 32'hffff_f0e2;
	localparam logic [31:0] ADDR_XFER_CHAN2    = 32'hffff_f0e4;
	localparam logic [31:0] ADDR_XFER_CHAN3    = 32'hffff_f0e6;
	localparam logic [31:0] ADDR_OSC_MODE      = 32'hffff_f80c;
	localparam logic [31:0] ADDR_WD_MODE       = 32'hffff_f6d0;
	localparam logic [31:0] ADDR_WD_RESTART    = 32'hffff_f6d1;

	// Guarded set, indexed by the select code that leaves on the guarded-write port.
	localparam int unsigned NGUARD = 7;
	localparam logic [2:0]  GSEL_POWER_SAVE = 3'h0;
	localparam logic [2:0]  GSEL_CLOCK      = 3'h1;
	localparam logic [2:0]  GSEL_PROC_CLOCK = 3'h2;
	localparam logic [2:0]  GSEL_CLOCK_MON  = 3'h3;
	localparam logic [2:0]  GSEL_RESET_SRC  = 3'h4;
	localparam logic [2:0]  GSEL_LOW_VOLT   = 3'h5;
	localparam logic [2:0]  GSEL_DEBUG_MODE = 3'h6;
	localparam logic [NGUARD*32-1:0] GUARD_ADDRS = {
		32'hffff_f9fc,
		32'hffff_f890,
		32'hffff_f888,
		32'hffff_f870,
		32'hffff_f828,
		32'hffff_f822,
		32'hffff_f1fe
	};

	localparam logic [7:0] XFER_CHAN_RST  = 8'h00;
	localparam logic [7:0] DEBUG_MODE_RST = 8'h01;
	localparam logic [7:0] OSC_MODE_RST   = 8'h00;
	localparam logic [7:0] WD_MODE_RST    = 8'h67;
	localparam logic [7:0] SYS_RST        = 8'h00;

	localparam int unsigned CHAN_EN_BIT    = 0;
	localparam int unsigned CHAN_TRIG_BIT  = 1;
	localparam int unsigned CHAN_INIT_BIT  = 2;
	localparam int unsigned CHAN_TC_BIT    = 7;
	localparam int unsigned DEBUG_MODE_BIT = 0;
	localparam int unsigned OSC_STOP_BIT   = 0;
	localparam int unsigned SYS_ILLEGAL_BIT = 0;
	localparam int unsigned WD_MODE_HI_BIT = 6;
	localparam int unsigned WD_MODE_LO_BIT = 5;
	localparam int unsigned WD_CLKSEL_BIT  = 4;
	localparam int unsigned WD_INTV_LSB    = 0;
	localparam int unsigned WD_INTV_W      = 4;

	// Internal oscillator modelled as a 1 MHz enable derived from the system clock.
	localparam int unsigned OSC_HZ      = 1_000_000;
	localparam int unsigned OSC_DIV     = CLK_HZ / OSC_HZ;
	localparam int unsigned WD_BASE_LOG = 8;

	// Store or single-bit manipulation applied to a register's old value.
	function automatic logic [7:0] pscfg_apply(input logic [7:0] old, input pscfg_req_t rq);
		logic [7:0] nv;
		nv = old;
		unique case (rq.op)
			PSCFG_OP_STORE: nv = rq.wdata;
			PSCFG_OP_SET:   nv[rq.bitn] = 1'b1;
			PSCFG_OP_CLR:   nv[rq.bitn] = 1'b0;
			PSCFG_OP_NOT:   nv[rq.bitn] = ~old[rq.bitn];
		endcase
		return nv;
	endfunction

endpackage

/* pscfg_wdog.sv */
// Purpose: Watchdog counter with stop, interrupt and reset modes.
// Assumes: tick_i is a one-cycle enable on clk_i.
// Notes:   Overflow restarts the count from zero.
`timescale 1ns/1ps
module pscfg_wdog #(
	parameter int unsigned CNT_W    = 24,
	parameter int unsigned BASE_LOG = pscfg_pkg::WD_BASE_LOG
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       srst_i,
	input  wire logic       tick_i,
	input  wire logic [1:0] mode_i,
	input  wire logic [3:0] intv_i,
	input  wire logic       restart_i,
	output logic            nmi_o,
	output logic            res_o
);

	logic [CNT_W-1:0] cnt_r;
	logic [4:0]       idx;
	logic             ovf;

	always_comb begin
		idx = 5'(intv_i) + 5'(BASE_LOG);
		if (idx > 5'(CNT_W - 1)) begin
			idx = 5'(CNT_W - 1);
		end
		ovf = tick_i && (mode_i != 2'b00) && cnt_r[idx];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
		end else if (srst_i || restart_i || mode_i == 2'b00 || ovf) begin
			cnt_r <= '0;
		end else if (tick_i) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Upper mode bit wins: reset mode regardless of the lower bit.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nmi_o <= 1'b0;
			res_o <= 1'b0;
		end else begin
			nmi_o <= ovf && (mode_i == 2'b01);
			res_o <= ovf && mode_i[1];
		end
	end

	a_wd_stop_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(mode_i == 2'b00) |=> !nmi_o && !res_o)
		else $error("stopped watchdog raised a request");

	a_wd_ovf_kind: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ovf && mode_i[1] |=> res_o && !nmi_o)
		else $error("reset mode overflow gave wrong request");

endmodule

/* protected_system_config_tb.sv */
// Purpose: Self-checking bench for the protected system configuration block.
// Assumes: Requests are one-cycle pulses driven just after a rising edge and taken at the next.
// Notes:   Watchdog runs are timed on the system clock with interval 0 or 1 to keep the run short.
`timescale 1ns/1ps
module protected_system_config_tb;

	localparam int LIMIT = 20000;

	logic                   clk_i;
	logic                   rst_n_i;
	logic                   int_rst_i;
	logic                   debug_reset_pin_i;
	logic [3:0]             terminal_count_flag_i;
	pscfg_pkg::pscfg_req_t  req_i;
	logic [7:0]             rdata_o;
	logic                   rvalid_o;
	logic [3:0]             chan_en_o;
	logic [3:0]             chan_init_o;
	logic [3:0]             soft_trig_o;
	pscfg_pkg::pscfg_gwr_t  gwr_o;
	logic                   illegal_store_o;
	logic                   debug_func_o;
	logic                   dbg_pulldown_o;
	logic                   osc_stop_o;
	logic                   wd_nmi_request_o;
	logic                   wd_reset_request_o;
	pscfg_pkg::pscfg_gwr_t  last_gwr;
	logic [3:0]             last_trig;
	logic [3:0]             last_init;
	int                     n_fail = 0;
	int                     comparisons = 0;
	int                     cycles = 0;
	int                     at;
	logic                   seen_nmi;
	logic                   seen_res;
	logic [31:0]            chan_a [4] = '{pscfg_pkg::ADDR_XFER_CHAN0, pscfg_pkg::ADDR_XFER_CHAN1,
		pscfg_pkg::ADDR_XFER_CHAN2, pscfg_pkg::ADDR_XFER_CHAN3};
	logic [7:0]             wd_val [4] = '{8'h30, 8'h31, 8'h50, 8'h10};
	int                     wd_lo [4]  = '{248, 504, 248, -1};

	pscfg_top pscfg_top_i (
		.clk_i                 (clk_i),
		.rst_n_i               (rst_n_i),
		.int_rst_i             (int_rst_i),
		.debug_reset_pin_i     (debug_reset_pin_i),
		.terminal_count_flag_i (terminal_count_flag_i),
		.req_i                 (req_i),
		.rdata_o               (rdata_o),
		.rvalid_o              (rvalid_o),
		.chan_en_o             (chan_en_o),
		.chan_init_o           (chan_init_o),
		.soft_trig_o           (soft_trig_o),
		.gwr_o                 (gwr_o),
		.illegal_store_o       (illegal_store_o),
		.debug_func_o          (debug_func_o),
		.dbg_pulldown_o        (dbg_pulldown_o),
		.osc_stop_o            (osc_stop_o),
		.wd_nmi_request_o      (wd_nmi_request_o),
		.wd_reset_request_o    (wd_reset_request_o)
	);

	always #20 clk_i = ~clk_i;

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_fail = n_fail + 1;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] gaddr(input int s);
		return pscfg_pkg::GUARD_ADDRS[s*32 +: 32];
	endfunction

	// Outputs that answer a write are captured in the cycle right after the taking edge.
	task automatic wr(input logic [31:0] a, input pscfg_pkg::pscfg_op_t op, input logic [2:0] b,
		input logic [7:0] d);
		@(posedge clk_i);
		req_i.wr <= 1'b1;
		req_i.addr <= a;
		req_i.op <= op;
		req_i.bitn <= b;
		req_i.wdata <= d;
		@(posedge clk_i);
		req_i.wr <= 1'b0;
		#1;
		last_gwr = gwr_o;
		last_trig = soft_trig_o;
		last_init = chan_init_o;
	endtask

	task automatic st(input logic [31:0] a, input logic [7:0] d);
		wr(a, pscfg_pkg::PSCFG_OP_STORE, 3'h0, d);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		req_i.rd <= 1'b1;
		req_i.addr <= a;
		@(posedge clk_i);
		req_i.rd <= 1'b0;
		#1;
		chk(rvalid_o, 1'b1);
		chk(rdata_o, exp);
	endtask

	task automatic pin(input logic v);
		@(posedge clk_i);
		debug_reset_pin_i <= v;
		repeat (4) @(posedge clk_i);
		#1;
	endtask

	initial begin
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		int_rst_i = 1'b0;
		debug_reset_pin_i = 1'b0;
		terminal_count_flag_i = 4'h0;
		req_i = '0;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 4; i++) rd_chk(chan_a[i], 8'h00);
		chk(chan_en_o, 4'h0);
		rd_chk(gaddr(6), 8'h01);
		chk(dbg_pulldown_o, 1'b1);
		rd_chk(pscfg_pkg::ADDR_OSC_MODE, 8'h00);
		rd_chk(pscfg_pkg::ADDR_WD_MODE, 8'h67);
		for (int i = 0; i < 4; i++) begin
			st(chan_a[i], 8'h01);
			chk(chan_en_o[i], 1'b1);
			rd_chk(chan_a[i], 8'h01);
			wr(chan_a[i], pscfg_pkg::PSCFG_OP_SET, 3'h1, 8'h00);
			chk(last_trig[i], 1'b1);
			wr(chan_a[i], pscfg_pkg::PSCFG_OP_NOT, 3'h2, 8'h00);
			chk(last_init[i], 1'b1);
			wr(chan_a[i], pscfg_pkg::PSCFG_OP_CLR, 3'h0, 8'h00);
			chk(chan_en_o[i], 1'b0);
		end
		@(posedge clk_i);
		terminal_count_flag_i <= 4'h1;
		rd_chk(chan_a[0], 8'h80);
		// A guarded store with no command ahead of it is refused and flagged.
		st(gaddr(2), 8'h80);
		chk(last_gwr.valid, 1'b0);
		chk(illegal_store_o, 1'b1);
		rd_chk(pscfg_pkg::ADDR_SYS_STATUS, 8'h01);
		st(pscfg_pkg::ADDR_SYS_STATUS, 8'h00);
		chk(illegal_store_o, 1'b0);
		chk(chan_en_o, 4'h0);
		for (int s = 0; s < 6; s++) begin
			st(pscfg_pkg::ADDR_PROTECT_CMD, 8'ha5);
			st(gaddr(s), 8'h10 + 8'(s));
			chk(last_gwr.valid, 1'b1);
			chk(last_gwr.sel, s);
			chk(last_gwr.data, 8'h10 + 8'(s));
			if (s == 0) begin
				// A power-save store is followed by five idle cycles, as software runs no-operations.
				repeat (5) @(posedge clk_i);
			end
		end
		chk(illegal_store_o, 1'b0);
		st(pscfg_pkg::ADDR_PROTECT_CMD, 8'h00);
		rd_chk(pscfg_pkg::ADDR_WD_MODE, 8'h67);
		wr(gaddr(3), pscfg_pkg::PSCFG_OP_NOT, 3'h3, 8'h00);
		chk(last_gwr.valid, 1'b1);
		chk({last_gwr.op, last_gwr.bitn}, {pscfg_pkg::PSCFG_OP_NOT, 3'h3});
		// A write between the command and the guarded store spends the unlock.
		st(pscfg_pkg::ADDR_PROTECT_CMD, 8'h00);
		st(pscfg_pkg::ADDR_OSC_MODE, 8'h00);
		st(gaddr(1), 8'h01);
		chk(last_gwr.valid, 1'b0);
		chk(illegal_store_o, 1'b1);
		st(pscfg_pkg::ADDR_SYS_STATUS, 8'h00);
		st(pscfg_pkg::ADDR_PROTECT_CMD, 8'h00);
		st(gaddr(6), 8'h00);
		rd_chk(gaddr(6), 8'h00);
		chk(dbg_pulldown_o, 1'b0);
		pin(1'b1);
		chk(debug_func_o, 1'b0);
		st(pscfg_pkg::ADDR_PROTECT_CMD, 8'h00);
		wr(gaddr(6), pscfg_pkg::PSCFG_OP_SET, 3'h0, 8'h00);
		rd_chk(gaddr(6), 8'h00);
		pin(1'b0);
		st(pscfg_pkg::ADDR_PROTECT_CMD, 8'h00);
		wr(gaddr(6), pscfg_pkg::PSCFG_OP_SET, 3'h0, 8'h00);
		rd_chk(gaddr(6), 8'h01);
		chk(debug_func_o, 1'b0);
		pin(1'b1);
		chk(debug_func_o, 1'b1);
		pin(1'b0);
		st(pscfg_pkg::ADDR_PROTECT_CMD, 8'h00);
		st(gaddr(6), 8'h00);
		wr(pscfg_pkg::ADDR_OSC_MODE, pscfg_pkg::PSCFG_OP_SET, 3'h0, 8'h00);
		// The stop output follows the mode register by one clock.
		@(posedge clk_i);
		#1;
		chk(osc_stop_o, 1'b1);
		st(pscfg_pkg::ADDR_WD_MODE, 8'h10);
		// An internal reset must restore the registers but leave the debug mode bit alone.
		@(posedge clk_i);
		int_rst_i <= 1'b1;
		@(posedge clk_i);
		int_rst_i <= 1'b0;
		rd_chk(gaddr(6), 8'h00);
		rd_chk(pscfg_pkg::ADDR_OSC_MODE, 8'h00);
		chk(osc_stop_o, 1'b0);
		rd_chk(pscfg_pkg::ADDR_WD_MODE, 8'h67);
		// The external pin reset, unlike the internal one, brings the debug mode bit back to one.
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd_chk(gaddr(6), 8'h01);
		chk(dbg_pulldown_o, 1'b1);
		chk(debug_func_o, 1'b0);
		for (int m = 0; m < 4; m++) begin
			st(pscfg_pkg::ADDR_WD_MODE, wd_val[m]);
			at = -1;
			seen_nmi = 1'b0;
			seen_res = 1'b0;
			for (int k = 0; k < 600; k++) begin
				@(posedge clk_i);
				#1;
				if (at < 0 && (wd_nmi_request_o === 1'b1 || wd_reset_request_o === 1'b1)) begin
					at = k;
					seen_nmi = wd_nmi_request_o;
					seen_res = wd_reset_request_o;
				end
			end
			chk(seen_nmi, wd_val[m][6:5] == 2'b01);
			chk(seen_res, wd_val[m][6]);
			chk(at >= wd_lo[m] && at <= wd_lo[m] + 16, 1'b1);
		end
		conclude();
	end

endmodule
